// ### src/pld_pkg.sv
// Purpose: Constants for the port-input and immediate-load decode block.
// Assumes: 10-bit instruction words, one word per machine cycle.
// Notes: Opcodes are full 10-bit patterns or prefix patterns with masks.
//
// What this block does
// RULE1: Read port two opcode copies port into accumulator.
// RULE2: Read port three opcode copies port, carry untouched.
// RULE3: Increment Y, wrap, skip next when zero.
// RULE4: Load immediate nibble into accumulator, carry untouched.
// RULE5: Consecutive accumulator loads: only first one executes.
// RULE6: Pointer pair load writes X and Y immediates.
// RULE7: Consecutive pointer pair loads: only first executes.
// RULE8: One word, one cycle; skipped word changes nothing. Code: a skipped load still updates last_q, extending its run.
`default_nettype none
package pld_pkg;
  // ************************************************************
  // Opcodes and field layout
  // ************************************************************
  localparam logic [9:0] OP_READ_PORT_TWO = 10'h262;
  localparam logic [9:0] OP_READ_PORT_THREE = 10'h263;
  localparam logic [9:0] OP_INC_ROW = 10'h013;
  localparam logic [5:0] OP_LOAD_ACC_PREFIX = 6'h07;
  localparam logic [1:0] OP_LOAD_PAIR_PREFIX = 2'h3;
  localparam int IMM_LSB = 0;
  localparam int IMM_X_LSB = 4;
  localparam int PREFIX6_LSB = 4;
  localparam int PREFIX2_LSB = 8;
  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  typedef enum logic [1:0] {PLD_OTHER, PLD_LOAD_ACC, PLD_LOAD_PAIR} pld_kind_t;
endpackage
`default_nettype wire

// ### src/pld_decode.sv
// Purpose: Classifies one instruction word for the load/input executor.
// Assumes: Word is stable during its machine cycle.
// Notes: Pure combinational decode; no state.
`default_nettype none
module pld_decode
  import pld_pkg::*;
(
  // Instruction word.
  input wire logic [9:0] instr_i,
  // Decoded strobes.
  output logic is_port_two_o,
  output logic is_port_three_o,
  output logic is_inc_row_o,
  output logic is_load_acc_o,
  output logic is_load_pair_o
);
  // Exact matches for the input and increment words, prefix matches for loads.
  assign is_port_two_o = (instr_i == OP_READ_PORT_TWO);
  assign is_port_three_o = (instr_i == OP_READ_PORT_THREE);
  assign is_inc_row_o = (instr_i == OP_INC_ROW);
  assign is_load_acc_o = (instr_i[9:PREFIX6_LSB] == OP_LOAD_ACC_PREFIX);
  assign is_load_pair_o = (instr_i[9:PREFIX2_LSB] == OP_LOAD_PAIR_PREFIX);
endmodule
`default_nettype wire

// ### src/pld_core.sv
// Purpose: Executes port reads, row increment and immediate loads.
// Assumes: One instruction per clock when instr_valid_i is high.
// Notes: Carry flag is held outside; this block never drives it.
`default_nettype none
module pld_core
  import pld_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Instruction stream.
  input wire logic instr_valid_i,
  input wire logic [9:0] instr_i,
  // Port levels.
  input wire logic [3:0] input_port_two_i,
  input wire logic [3:0] input_port_three_i,
  // Architectural state and skip strobe.
  output logic [3:0] acc_o,
  output logic [3:0] reg_x_o,
  output logic [3:0] reg_y_o,
  output logic skipped_o
);
  // ************************************************************
  // Decode
  // ************************************************************
  // Decoded strobes for the current word.
  logic dec_port_two;
  logic dec_port_three;
  logic dec_inc_row;
  logic dec_load_acc;
  logic dec_load_pair;
  // Architectural registers and their next values.
  logic [3:0] acc_q;
  logic [3:0] acc_d;
  logic [3:0] x_q;
  logic [3:0] x_d;
  logic [3:0] y_q;
  logic [3:0] y_d;
  // Pending skip and the kind of the last valid word, for run detection.
  logic skip_q;
  logic skip_d;
  pld_kind_t last_q;
  pld_kind_t last_d;
  pld_kind_t kind_now;
  // Immediate fields and the incremented row pointer.
  logic [3:0] imm_low;
  logic [3:0] imm_high;
  logic [3:0] y_inc;
  logic run_skip;
  logic skip_now;
  logic exec;

  pld_decode i_pld_decode (
    .instr_i(instr_i),
    .is_port_two_o(dec_port_two),
    .is_port_three_o(dec_port_three),
    .is_inc_row_o(dec_inc_row),
    .is_load_acc_o(dec_load_acc),
    .is_load_pair_o(dec_load_pair)
  );

  // Both immediates are sliced once so the executor and the checks agree on position.
  assign imm_low = instr_i[IMM_LSB +: 4];
  assign imm_high = instr_i[IMM_X_LSB +: 4];
  // Kind of the current word as the run detector sees it.
  assign kind_now = dec_load_acc ? PLD_LOAD_ACC :
                    (dec_load_pair ? PLD_LOAD_PAIR : PLD_OTHER);

  // ************************************************************
  // Skip and run detection
  // ************************************************************
  // A load following a load of the same kind is dropped, even without a skip flag.
  // A skipped load still extends its run, so only a word of another kind ends it.
  assign run_skip = (dec_load_acc && last_q == PLD_LOAD_ACC) ||
                    (dec_load_pair && last_q == PLD_LOAD_PAIR); // RULE5 RULE7
  assign skip_now = skip_q || run_skip; // RULE8
  // Only a valid word that is not skipped may touch acc, X or Y.
  assign exec = instr_valid_i && !skip_now;
  assign y_inc = y_q + 4'h1; // RULE3

  // ************************************************************
  // Next state
  // ************************************************************
  // Every word is decoded in full; the executor applies at most one effect per cycle.
  always_comb begin
    acc_d = acc_q;
    x_d = x_q;
    y_d = y_q;
    skip_d = skip_q;
    last_d = last_q;
    if (instr_valid_i) begin
      // A valid word consumes any pending skip; idle cycles leave it armed.
      skip_d = 1'b0;
      last_d = kind_now;
    end
    if (exec) begin
      if (dec_port_two) begin
        acc_d = input_port_two_i; // RULE1
      end else if (dec_port_three) begin
        acc_d = input_port_three_i; // RULE2
      end else if (dec_inc_row) begin
        y_d = y_inc; // RULE3
        // Assigned after the clear above, so a new skip wins over consuming the old one.
        skip_d = (y_inc == 4'h0); // RULE3
      end else if (dec_load_acc) begin
        acc_d = imm_low; // RULE4
      end else if (dec_load_pair) begin
        x_d = imm_high; // RULE6
        y_d = imm_low; // RULE6
      end
    end
  end

  // ************************************************************
  // State registers
  // ************************************************************
  // Synchronous reset; every register loads its next value on every edge.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      acc_q <= RST_NIBBLE;
      x_q <= RST_NIBBLE;
      y_q <= RST_NIBBLE;
      skip_q <= 1'b0;
      last_q <= PLD_OTHER;
    end else begin
      acc_q <= acc_d;
      x_q <= x_d;
      y_q <= y_d;
      skip_q <= skip_d;
      last_q <= last_d;
    end
  end

  // Data outputs come straight from registers; the skip strobe is combinational.
  assign acc_o = acc_q;
  assign reg_x_o = x_q;
  assign reg_y_o = y_q;
  assign skipped_o = instr_valid_i && skip_now;

  // ************************************************************
  // Checks
  // ************************************************************
  // Port reads land in the accumulator one edge after their word.
  property p_port_two;
    @(posedge clk_i) disable iff (!rst_b_i)
    (exec && dec_port_two) |=> (acc_o == $past(input_port_two_i));
  endproperty
  a_port_two: assert property (p_port_two) else $error("port two read wrong"); // RULE1
  property p_port_three;
    @(posedge clk_i) disable iff (!rst_b_i)
    (exec && dec_port_three) |=> (acc_o == $past(input_port_three_i));
  endproperty
  a_port_three: assert property (p_port_three) else $error("port three read wrong"); // RULE2
  // A wrap to zero arms the skip and applies it to the next valid word.
  property p_inc_skip;
    @(posedge clk_i) disable iff (!rst_b_i)
    (exec && dec_inc_row && y_q == 4'hf) |=>
      (reg_y_o == 4'h0) && skip_q && (!instr_valid_i || skipped_o);
  endproperty
  a_inc_skip: assert property (p_inc_skip) else $error("row wrap did not skip"); // RULE3
  property p_inc_noskip;
    @(posedge clk_i) disable iff (!rst_b_i)
    (exec && dec_inc_row && y_q != 4'hf) |=> (reg_y_o == $past(y_q) + 4'h1) && !skip_q;
  endproperty
  a_inc_noskip: assert property (p_inc_noskip) else $error("row increment wrong"); // RULE3
  // An armed skip survives idle cycles until a valid word takes it.
  property p_skip_kept;
    @(posedge clk_i) disable iff (!rst_b_i)
    (skip_q && !instr_valid_i) |=> skip_q;
  endproperty
  a_skip_kept: assert property (p_skip_kept) else $error("pending skip lost"); // RULE3
  property p_y_source;
    @(posedge clk_i) disable iff (!rst_b_i)
    !(exec && (dec_inc_row || dec_load_pair)) |=> $stable(reg_y_o);
  endproperty
  a_y_source: assert property (p_y_source) else $error("row pointer changed"); // RULE3
  // Accumulator loads and the words that may write it.
  property p_load_acc;
    @(posedge clk_i) disable iff (!rst_b_i)
    (exec && dec_load_acc) |=> (acc_o == $past(imm_low));
  endproperty
  a_load_acc: assert property (p_load_acc) else $error("accumulator load wrong"); // RULE4
  property p_acc_source;
    @(posedge clk_i) disable iff (!rst_b_i)
    !(exec && (dec_port_two || dec_port_three || dec_load_acc)) |=> $stable(acc_o);
  endproperty
  a_acc_source: assert property (p_acc_source) else $error("accumulator changed"); // RULE4
  // Runs of accumulator loads: the second is dropped, another kind ends the run.
  property p_acc_run;
    @(posedge clk_i) disable iff (!rst_b_i)
    (instr_valid_i && dec_load_acc) ##1 (instr_valid_i && dec_load_acc) |-> skipped_o;
  endproperty
  a_acc_run: assert property (p_acc_run) else $error("second load in run ran"); // RULE5
  property p_run_breaks;
    @(posedge clk_i) disable iff (!rst_b_i)
    (instr_valid_i && !dec_load_acc) ##1 (instr_valid_i && dec_load_acc && !skip_q) |->
      !skipped_o;
  endproperty
  a_run_breaks: assert property (p_run_breaks) else $error("load after other word dropped"); // RULE5
  // Pointer pair loads and the words that may write X.
  property p_load_pair;
    @(posedge clk_i) disable iff (!rst_b_i)
    (exec && dec_load_pair) |=> (reg_x_o == $past(imm_high) && reg_y_o == $past(imm_low));
  endproperty
  a_load_pair: assert property (p_load_pair) else $error("pointer pair load wrong"); // RULE6
  property p_x_source;
    @(posedge clk_i) disable iff (!rst_b_i)
    !(exec && dec_load_pair) |=> $stable(reg_x_o);
  endproperty
  a_x_source: assert property (p_x_source) else $error("column pointer changed"); // RULE6
  property p_pair_run;
    @(posedge clk_i) disable iff (!rst_b_i)
    (instr_valid_i && dec_load_pair) ##1 (instr_valid_i && dec_load_pair) |-> skipped_o;
  endproperty
  a_pair_run: assert property (p_pair_run) else $error("second pair load ran"); // RULE7
  // Skipped words and idle cycles leave acc, X and Y as they were.
  property p_skip_holds;
    @(posedge clk_i) disable iff (!rst_b_i)
    skipped_o |=> $stable(acc_o) && $stable(reg_x_o) && $stable(reg_y_o);
  endproperty
  a_skip_holds: assert property (p_skip_holds) else $error("skipped word changed state"); // RULE8
  property p_idle_holds;
    @(posedge clk_i) disable iff (!rst_b_i)
    !instr_valid_i |=> $stable(acc_o) && $stable(reg_x_o) && $stable(reg_y_o);
  endproperty
  a_idle_holds: assert property (p_idle_holds) else $error("idle cycle changed state"); // RULE8
  // Reset clears the registers, the armed skip and the run memory.
  property p_reset_clears;
    @(posedge clk_i)
    !rst_b_i |=> (acc_o == RST_NIBBLE && reg_x_o == RST_NIBBLE && reg_y_o == RST_NIBBLE &&
      !skip_q && last_q == PLD_OTHER);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left state"); // RULE8
endmodule
`default_nettype wire

// ### verification/pld_prog_model.sv
// Purpose: Program memory and port pins that feed the decode block.
// Assumes: One word per cycle while run_i is high; bench fills rom beforehand.
// Notes: Port levels change every fetch cycle so a stale sample cannot pass.
`default_nettype none
module pld_prog_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Fetch control.
  input wire logic run_i,
  // Fetched word and pins.
  output logic instr_valid_o,
  output logic [9:0] instr_o,
  output logic [3:0] port_two_o,
  output logic [3:0] port_three_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Storage and fetch
  // ************************************************************
  logic [9:0] rom [16];
  logic [3:0] pc_q;
  // Outside a fetch the bus shows the inverse word, never a held copy.
  assign instr_valid_o = run_i;
  assign instr_o = run_i ? rom[pc_q] : ~rom[pc_q];
  assign port_two_o = 4'ha ^ pc_q;
  assign port_three_o = 4'h5 ^ pc_q;
  // The counter restarts whenever fetching pauses.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !run_i) pc_q <= 4'h0;
    else pc_q <= pc_q + 4'h1;
  end
endmodule
`default_nettype wire

// ### verification/cpu_port_input_and_load_ops_bench.sv
// Purpose: Self-checking bench for the port-input and immediate-load core.
// Assumes: Each scenario starts from reset so no run or skip carries over.
// Notes: Expected port levels follow the model pattern per word index.
`default_nettype none
module cpu_port_input_and_load_ops_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic run = 1'b0;
  logic valid;
  logic [9:0] instr;
  logic [3:0] port_two;
  logic [3:0] port_three;
  logic [3:0] acc;
  logic [3:0] reg_x;
  logic [3:0] reg_y;
  logic skipped;
  int n_fail = 0;
  int compares = 0;
  always #10 clk_i = ~clk_i;
  pld_prog_model i_pld_prog_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .run_i(run),
    .instr_valid_o(valid), .instr_o(instr),
    .port_two_o(port_two), .port_three_o(port_three));
  pld_core i_pld_core (.clk_i(clk_i), .rst_b_i(rst_b_i), .instr_valid_i(valid),
    .instr_i(instr), .input_port_two_i(port_two), .input_port_three_i(port_three),
    .acc_o(acc), .reg_x_o(reg_x), .reg_y_o(reg_y), .skipped_o(skipped));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Reset, then start fetching from word zero.
  task automatic start();
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(negedge clk_i);
    chk("acc", acc, 4'h0);
    chk("x", reg_x, 4'h0);
    chk("y", reg_y, 4'h0);
    @(posedge clk_i);
    run <= 1'b1;
    @(negedge clk_i);
  endtask
  // Skip flag is judged mid-cycle, registers one cycle later.
  task automatic step(input logic es, input logic [3:0] ea, ex, ey, input logic last);
    chk("skip", {3'h0, skipped}, {3'h0, es});
    @(posedge clk_i);
    if (last) run <= 1'b0;
    @(negedge clk_i);
    chk("acc", acc, ea);
    chk("x", reg_x, ex);
    chk("y", reg_y, ey);
  endtask
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_ports();
    i_pld_prog_model.rom[0] = 10'h262;
    i_pld_prog_model.rom[1] = 10'h263;
    start();
    step(1'b0, 4'ha, 4'h0, 4'h0, 1'b0);
    step(1'b0, 4'h4, 4'h0, 4'h0, 1'b1);
  endtask
  // Wrap to zero skips a load; a nonzero result does not skip.
  task automatic t_inc();
    i_pld_prog_model.rom[0] = 10'h33f;
    i_pld_prog_model.rom[1] = 10'h013;
    i_pld_prog_model.rom[2] = 10'h077;
    i_pld_prog_model.rom[3] = 10'h013;
    i_pld_prog_model.rom[4] = 10'h262;
    start();
    step(1'b0, 4'h0, 4'h3, 4'hf, 1'b0);
    step(1'b0, 4'h0, 4'h3, 4'h0, 1'b0);
    step(1'b1, 4'h0, 4'h3, 4'h0, 1'b0);
    step(1'b0, 4'h0, 4'h3, 4'h1, 1'b0);
    step(1'b0, 4'he, 4'h3, 4'h1, 1'b1);
  endtask
  // Runs of each load kind; a change of kind starts a new run.
  task automatic t_runs();
    i_pld_prog_model.rom[0] = 10'h075;
    i_pld_prog_model.rom[1] = 10'h079;
    i_pld_prog_model.rom[2] = 10'h07c;
    i_pld_prog_model.rom[3] = 10'h3a1;
    i_pld_prog_model.rom[4] = 10'h312;
    i_pld_prog_model.rom[5] = 10'h078;
    start();
    step(1'b0, 4'h5, 4'h0, 4'h0, 1'b0);
    step(1'b1, 4'h5, 4'h0, 4'h0, 1'b0);
    step(1'b1, 4'h5, 4'h0, 4'h0, 1'b0);
    step(1'b0, 4'h5, 4'ha, 4'h1, 1'b0);
    step(1'b1, 4'h5, 4'ha, 4'h1, 1'b0);
    step(1'b0, 4'h8, 4'ha, 4'h1, 1'b1);
  endtask
  // Reset drops a skip armed by a row wrap, so the port read and load after it both run.
  task automatic t_reset();
    i_pld_prog_model.rom[0] = 10'h073;
    i_pld_prog_model.rom[1] = 10'h33f;
    i_pld_prog_model.rom[2] = 10'h013;
    start();
    step(1'b0, 4'h3, 4'h0, 4'h0, 1'b0);
    step(1'b0, 4'h3, 4'h3, 4'hf, 1'b0);
    step(1'b0, 4'h3, 4'h3, 4'h0, 1'b1);
    repeat (2) @(negedge clk_i);
    i_pld_prog_model.rom[0] = 10'h262;
    i_pld_prog_model.rom[1] = 10'h07b;
    start();
    step(1'b0, 4'ha, 4'h0, 4'h0, 1'b0);
    step(1'b0, 4'hb, 4'h0, 4'h0, 1'b1);
  endtask
  initial begin
    t_ports();
    t_inc();
    t_runs();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
